// [shared/expander_pkg.sv]
package expander_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int PORT_W   = 8;
    localparam int STRAP_W  = 3;
    localparam int CNT_W    = 4;

    ////////////////////////////////////////////////////////////////////////////
    // slave address: fixed upper bits, straps fill the low three
    localparam logic [3:0] ADDR_FIXED = 4'h7;

    ////////////////////////////////////////////////////////////////////////////
    // register selects (low two command bits)
    localparam logic [1:0] SEL_INPUT  = 2'h0;
    localparam logic [1:0] SEL_LATCH  = 2'h1;
    localparam logic [1:0] SEL_INVERT = 2'h2;
    localparam logic [1:0] SEL_DIR    = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] LATCH_RESET  = 8'hFF;
    localparam logic [7:0] INVERT_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET    = 8'hFF;
    localparam logic [7:0] CMD_RESET    = 8'h00;
    localparam logic [7:0] SNAP_RESET   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // bit counting
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [3:0] LAST_TX_BIT  = 4'h7;
    localparam logic [3:0] CNT_RESET    = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // link states, gray steps along the write and the read path
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h3,
        ST_CMD       = 4'h2,
        ST_CMD_ACK   = 4'h6,
        ST_WDATA     = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA     = 4'hB,
        ST_RACK      = 4'hF
    } link_state_e;

endpackage

// [shared/line_event_if.sv]
`timescale 1ns/1ps
interface line_event_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;

    modport source (
        output scl_rise,
        output scl_fall,
        output start,
        output stop,
        output sda
    );

    modport sink (
        input scl_rise,
        input scl_fall,
        input start,
        input stop,
        input sda
    );
endinterface

// [core/sync_2ff.sv]
`timescale 1ns/1ps
module sync_2ff #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // stage1 feeds only sync_out
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            stage1   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// [core/line_monitor.sv]
`timescale 1ns/1ps
module line_monitor (
    input  wire logic   ref_clk,
    input  wire logic   nrst,
    input  wire logic   scl_s,
    input  wire logic   sda_s,
    line_event_if.source ev
);

    logic scl_q;
    logic sda_q;

    // idle bus is high; resetting to one avoids a false edge at release
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign ev.scl_rise = scl_s & ~scl_q;
    assign ev.scl_fall = ~scl_s & scl_q;
    assign ev.start    = scl_s & scl_q & sda_q & ~sda_s;
    assign ev.stop     = scl_s & scl_q & ~sda_q & sda_s;
    assign ev.sda      = sda_s;

endmodule

// [core/io_expander_core.sv]
// Contract
// - answer to address with fixed upper bits and strap pins in the low three
// - last address bit one means read, zero means write
// - first byte after acknowledged write address is stored as the command
// - command low bits select input, latch, invert or direction register
// - stored pointer persists until a new command byte arrives
// - input register reads actual pin levels for all pins, after inversion
// - writes to the input register are discarded
// - latch resets to all ones and reads back the flip-flops, not pins
// - latch bit drives its pin only when that pin is an output
// - invert bit flips reported level of input pins; resets to zeros
// - direction one means input with driver off; resets to all ones
// - write is start, address, pointer, data, stop; address, pointer and data acknowledged
// - no auto-increment on writes; the last data byte stays
// - read is write of command, repeated start, read address, then data
// - multi-byte reads keep returning the pointed register
// - read data captured at rising clock of the preceding acknowledge
// - stop may end a read anytime; last captured data is valid
// - pull data low during acknowledge after each received byte; a foreign address byte is left unacknowledged
// - interrupt clears at acknowledge rising edge when input register is read
// - interrupt asserts while an input pin differs from last read level
`timescale 1ns/1ps
module io_expander_core (
    input  wire logic                        ref_clk,
    input  wire logic                        nrst,
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    input  wire logic                        addr_strap_bit0,
    input  wire logic                        addr_strap_bit1,
    input  wire logic                        addr_strap_bit2,
    input  wire logic [expander_pkg::PORT_W-1:0] port_pin_in,
    output logic      [expander_pkg::PORT_W-1:0] port_pin_out,
    output logic      [expander_pkg::PORT_W-1:0] port_pin_oe,
    output logic                             irq_n_out,
    output logic                             irq_n_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [1:0]                            line_s;
    logic                                  scl_s;
    logic                                  sda_s;
    logic [expander_pkg::STRAP_W-1:0]      strap_s;
    logic [expander_pkg::PORT_W-1:0]       pin_s;

    expander_pkg::link_state_e             state;
    expander_pkg::link_state_e             next_state;
    logic [expander_pkg::CNT_W-1:0]        bit_cnt;
    logic [7:0]                            rx_shift;
    logic [7:0]                            tx_shift;

    logic [7:0]                            command_pointer;
    logic [expander_pkg::PORT_W-1:0]       pin_output_latch;
    logic [expander_pkg::PORT_W-1:0]       input_polarity_invert;
    logic [expander_pkg::PORT_W-1:0]       pin_direction;
    logic [expander_pkg::PORT_W-1:0]       pin_input_levels;
    logic [expander_pkg::PORT_W-1:0]       level_snapshot;
    logic                                  snapshot_primed;
    logic [1:0]                            prime_wait;
    logic                                  irq_drive;

    logic [6:0]                            own_addr;
    logic                                  addr_match;
    logic [1:0]                            reg_select;
    logic [7:0]                            selected_value;
    logic                                  rx_state;
    logic                                  byte_done;
    logic                                  data_write;
    logic                                  tx_capture;
    logic                                  irq_pending;

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers and line event detection

    sync_2ff #(
        .WIDTH     (2),
        .RESET_VAL (2'h3)
    ) u_line_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in ({scl_in, sda_in}),
        .sync_out (line_s)
    );

    assign scl_s = line_s[1];
    assign sda_s = line_s[0];

    sync_2ff #(
        .WIDTH     (expander_pkg::STRAP_W),
        .RESET_VAL (3'h0)
    ) u_strap_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in ({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
        .sync_out (strap_s)
    );

    sync_2ff #(
        .WIDTH     (expander_pkg::PORT_W),
        .RESET_VAL (8'h00)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (port_pin_in),
        .sync_out (pin_s)
    );

    line_event_if ev ();

    line_monitor u_monitor (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .scl_s   (scl_s),
        .sda_s   (sda_s),
        .ev      (ev.source)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address, selection and readable values

    // straps are sampled continuously; they must hold still during a transfer
    assign own_addr   = {expander_pkg::ADDR_FIXED, strap_s};
    assign addr_match = (rx_shift[7:1] == own_addr);
    assign reg_select = command_pointer[1:0];

    // inversion applies only to pins set as inputs
    assign pin_input_levels = pin_s ^ (input_polarity_invert & pin_direction);

    always_comb begin
        unique case (reg_select)
            expander_pkg::SEL_INPUT:  selected_value = pin_input_levels;
            expander_pkg::SEL_LATCH:  selected_value = pin_output_latch;
            expander_pkg::SEL_INVERT: selected_value = input_polarity_invert;
            expander_pkg::SEL_DIR:    selected_value = pin_direction;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // link state machine

    assign rx_state  = (state == expander_pkg::ST_ADDR) ||
                       (state == expander_pkg::ST_CMD) ||
                       (state == expander_pkg::ST_WDATA);
    assign byte_done = rx_state && ev.scl_fall && (bit_cnt == expander_pkg::BYTE_BITS);

    always_comb begin
        next_state = state;
        if (ev.start) begin
            next_state = expander_pkg::ST_ADDR;
        end else if (ev.stop) begin
            next_state = expander_pkg::ST_IDLE;
        end else begin
            unique case (state)
                expander_pkg::ST_IDLE: begin
                    next_state = expander_pkg::ST_IDLE;
                end
                expander_pkg::ST_ADDR: begin
                    if (byte_done) begin
                        // a foreign address parks the machine until the next start
                        next_state = addr_match ? expander_pkg::ST_ADDR_ACK
                                                : expander_pkg::ST_IDLE;
                    end
                end
                expander_pkg::ST_ADDR_ACK: begin
                    if (ev.scl_fall) begin
                        next_state = rx_shift[0] ? expander_pkg::ST_RDATA
                                                 : expander_pkg::ST_CMD;
                    end
                end
                expander_pkg::ST_CMD: begin
                    if (byte_done) begin
                        next_state = expander_pkg::ST_CMD_ACK;
                    end
                end
                expander_pkg::ST_CMD_ACK: begin
                    if (ev.scl_fall) begin
                        next_state = expander_pkg::ST_WDATA;
                    end
                end
                expander_pkg::ST_WDATA: begin
                    if (byte_done) begin
                        next_state = expander_pkg::ST_WDATA_ACK;
                    end
                end
                expander_pkg::ST_WDATA_ACK: begin
                    if (ev.scl_fall) begin
                        next_state = expander_pkg::ST_WDATA;
                    end
                end
                expander_pkg::ST_RDATA: begin
                    if (ev.scl_fall && (bit_cnt == expander_pkg::LAST_TX_BIT)) begin
                        next_state = expander_pkg::ST_RACK;
                    end
                end
                expander_pkg::ST_RACK: begin
                    if (ev.scl_rise && ev.sda) begin
                        next_state = expander_pkg::ST_IDLE;
                    end else if (ev.scl_fall) begin
                        next_state = expander_pkg::ST_RDATA;
                    end
                end
                default: begin
                    next_state = expander_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state <= expander_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit counter and receive shifter

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            bit_cnt <= expander_pkg::CNT_RESET;
        end else if (ev.start || (next_state != state)) begin
            bit_cnt <= expander_pkg::CNT_RESET;
        end else if (rx_state && ev.scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
        end else if ((state == expander_pkg::ST_RDATA) && ev.scl_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // sampled on rising clock, when data is stable
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_shift <= 8'h00;
        end else if (rx_state && ev.scl_rise) begin
            rx_shift <= {rx_shift[6:0], ev.sda};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command pointer and writable registers

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            command_pointer <= expander_pkg::CMD_RESET;
        end else if ((state == expander_pkg::ST_CMD) && byte_done) begin
            command_pointer <= rx_shift;
        end
    end

    // every data byte lands in the same register
    assign data_write = (state == expander_pkg::ST_WDATA) && byte_done;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_output_latch <= expander_pkg::LATCH_RESET;
        end else if (data_write && (reg_select == expander_pkg::SEL_LATCH)) begin
            pin_output_latch <= rx_shift;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            input_polarity_invert <= expander_pkg::INVERT_RESET;
        end else if (data_write && (reg_select == expander_pkg::SEL_INVERT)) begin
            input_polarity_invert <= rx_shift;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_direction <= expander_pkg::DIR_RESET;
        end else if (data_write && (reg_select == expander_pkg::SEL_DIR)) begin
            pin_direction <= rx_shift;
        end
    end
    // a data write with the input select matches no branch above: dropped

    ////////////////////////////////////////////////////////////////////////////
    // transmit shifter

    // load at rising clock of address ack (read) or of a master ack
    assign tx_capture = ev.scl_rise &&
                        (((state == expander_pkg::ST_ADDR_ACK) && rx_shift[0]) ||
                         ((state == expander_pkg::ST_RACK) && !ev.sda));

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tx_shift <= 8'h00;
        end else if (tx_capture) begin
            tx_shift <= selected_value;
        end else if ((state == expander_pkg::ST_RDATA) && ev.scl_fall &&
                     (bit_cnt != expander_pkg::LAST_TX_BIT)) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data line drive (open drain)

    assign sda_out = 1'b0;
    assign sda_oe  = (state == expander_pkg::ST_ADDR_ACK) ||
                     (state == expander_pkg::ST_CMD_ACK) ||
                     (state == expander_pkg::ST_WDATA_ACK) ||
                     ((state == expander_pkg::ST_RDATA) && !tx_shift[7]);

    ////////////////////////////////////////////////////////////////////////////
    // port pins

    assign port_pin_out = pin_output_latch;
    assign port_pin_oe  = ~pin_direction;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: compare input pins against the level last read

    // baseline keeps reloading until the pin synchroniser holds real levels,
    // otherwise its reset value would raise a false interrupt after reset
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            prime_wait      <= 2'h0;
            snapshot_primed <= 1'b0;
        end else begin
            prime_wait      <= {prime_wait[0], 1'b1};
            snapshot_primed <= prime_wait[1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            level_snapshot <= expander_pkg::SNAP_RESET;
        end else if (!snapshot_primed) begin
            level_snapshot <= pin_input_levels;
        end else if (tx_capture && (reg_select == expander_pkg::SEL_INPUT)) begin
            level_snapshot <= pin_input_levels;
        end
    end

    // output pins never interrupt; a change landing on the capture edge still interrupts
    assign irq_pending = |((pin_input_levels ^ level_snapshot) & pin_direction);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq_drive <= 1'b0;
        end else begin
            irq_drive <= irq_pending && snapshot_primed;
        end
    end

    assign irq_n_out = 1'b0;
    assign irq_n_oe  = irq_drive;

endmodule

// [bench/bus_master.sv]
`timescale 1ns/1ps
module bus_master (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // quarter of a 125 ns bus clock, free of the system clock phase
    localparam realtime QTR = 31.25;

    // clock stands high and data is released outside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // start and repeated start alike: data falls while the clock is high
    task automatic start();
        sda_low = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b1;
        #QTR scl = 1'b0;
    endtask

    // data rises while the clock is high; ends a read at any byte boundary
    task automatic stop();
        sda_low = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b0;
        #QTR;
    endtask

    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        #QTR scl = 1'b1;
        #QTR r = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    // msb first, then the ninth bit; nack high leaves the line up after the last read byte
    task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(nack, a);
        ack = ~a;
    endtask
endmodule

// [bench/io_expander_core_chk.sv]
`timescale 1ns/1ps
module io_expander_chk (
    input wire logic                              ref_clk,
    input wire logic                              nrst,
    input wire logic                              scl_in,
    input wire logic                              sda_in,
    input wire logic                              sda_out,
    input wire logic                              sda_oe,
    input wire logic                              addr_strap_bit0,
    input wire logic                              addr_strap_bit1,
    input wire logic                              addr_strap_bit2,
    input wire logic [expander_pkg::PORT_W-1:0]   port_pin_in,
    input wire logic [expander_pkg::PORT_W-1:0]   port_pin_out,
    input wire logic [expander_pkg::PORT_W-1:0]   port_pin_oe,
    input wire logic                              irq_n_out,
    input wire logic                              irq_n_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////
    // an acknowledge or read bit must stay driven for eight system clocks from its rise, past the next bus clock rising edge
    sequence drive_held_s;
        sda_oe [*8];
    endsequence
    sequence irq_quiet_s;
        !irq_n_oe [*4];
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    AST_OPEN_DRAIN: assert property (sda_out == 1'b0 && irq_n_out == 1'b0)
        else $error("open drain output drives high");
    AST_RESET_DEFAULTS: assert property ($rose(nrst) |-> port_pin_out == 8'hFF && port_pin_oe == 8'h00)
        else $error("port defaults wrong after reset");
    AST_IRQ_QUIET_AFTER_RESET: assert property ($rose(nrst) |-> irq_quiet_s)
        else $error("interrupt asserted right after reset");
    AST_LATCH_MOVES_LOW: assert property ($changed(port_pin_out) |-> !scl_in && !$past(scl_in))
        else $error("latch changed outside a bus clock low phase");
    AST_DIR_MOVES_LOW: assert property ($changed(port_pin_oe) |-> !scl_in && !$past(scl_in))
        else $error("pin enables changed outside a bus clock low phase");
    AST_SDA_MOVES_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line changed while bus clock high");
    AST_ACK_HOLDS: assert property ($rose(sda_oe) |-> drive_held_s)
        else $error("data line drive released too early");
    AST_IRQ_NEEDS_INPUT: assert property ($rose(irq_n_oe) |-> $past(port_pin_oe) != 8'hFF)
        else $error("interrupt with no input pin");
endmodule

bind io_expander_core io_expander_chk io_expander_chk_inst (
    .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0(addr_strap_bit0), .addr_strap_bit1(addr_strap_bit1), .addr_strap_bit2(addr_strap_bit2),
    .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe)
);

// [bench/i2c_eight_bit_io_expander_regs_bench.sv]
`timescale 1ns/1ps
module i2c_eight_bit_io_expander_regs_bench;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
        logic [7:0] back;
        logic [7:0] pins;
        logic [7:0] oe;
    } row_s;

    logic       ref_clk, nrst, sda_out, sda_oe, scl, m_low, irq_n_out, irq_n_oe, ak;
    logic [2:0] strap;
    logic [7:0] ext, pin_out, pin_oe, pins, q, lat;
    wire logic  sda;
    int         mismatches, checks_done, cycles;
    row_s       rows [5] = '{
        '{8'h01, 8'h55, 8'h55, 8'h55, 8'h00},
        '{8'h02, 8'hA5, 8'hA5, 8'h55, 8'h00},
        '{8'hFF, 8'h0F, 8'h0F, 8'h55, 8'hF0},
        '{8'hFD, 8'hC3, 8'hC3, 8'hC3, 8'hF0},
        '{8'h00, 8'h12, 8'hC3, 8'hC3, 8'hF0}
    };

    // pulled-up wire; driven pins show the latch, the rest the outside level
    assign sda = ~(sda_oe | m_low);
    assign pins = (pin_oe & pin_out) | (~pin_oe & ext);

    io_expander_core io_expander_core_inst (
        .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
        .port_pin_in(pins), .port_pin_out(pin_out), .port_pin_oe(pin_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe)
    );
    bus_master bus_master_inst (.scl(scl), .sda_low(m_low), .sda(sda));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end
        else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            $display("BAD t=%0t run hung", $time);
            report_and_stop();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic put(input logic [7:0] d, input string what);
        bus_master_inst.xfer(d, 1'b1, q, ak);
        chk({7'h00, ak}, 8'h01, what);
    endtask

    // start, own address with write direction, command byte
    task automatic open_w(input logic [7:0] cmd);
        @(posedge ref_clk);
        #2;
        bus_master_inst.start();
        put({expander_pkg::ADDR_FIXED, strap, 1'b0}, "write address");
        put(cmd, "command");
    endtask

    task automatic rd(input logic [7:0] cmd, input logic use_cmd, input int n, input logic [7:0] exp);
        if (use_cmd) begin
            open_w(cmd);
        end
        else begin
            @(posedge ref_clk);
            #2;
        end
        bus_master_inst.start();
        put({expander_pkg::ADDR_FIXED, strap, 1'b1}, "read address");
        for (int i = 0; i < n; i++) begin
            bus_master_inst.xfer(8'hFF, i == n - 1, q, ak);
            chk(q, exp, "read data");
        end
        bus_master_inst.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst <= 1'b0;
        strap <= 3'h0;
        ext <= 8'h96;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #2;
        chk({7'h00, irq_n_oe}, 8'h00, "no interrupt after reset");
        foreach (rows[i]) begin
            open_w(rows[i].cmd);
            put(rows[i].data, "data");
            bus_master_inst.stop();
            rd(rows[i].cmd, 1'b1, 1, rows[i].back);
            chk(pin_out, rows[i].pins, "latch pins");
            chk(pin_oe, rows[i].oe, "pin enables");
            $display("row %0d done", i);
        end
        open_w(8'h01);
        put(8'hAA, "data");
        put(8'h3C, "data");
        bus_master_inst.stop();
        lat = 8'h3C;
        chk(pin_out, lat, "last byte kept");
        rd(8'h00, 1'b0, 3, lat);
        $display("repeat access done");
        for (int s = 0; s < 8; s++) begin
            @(posedge ref_clk);
            strap <= 3'(s);
            repeat (4) @(posedge ref_clk);
            #2;
            bus_master_inst.start();
            bus_master_inst.xfer({expander_pkg::ADDR_FIXED, strap ^ 3'h1, 1'b0}, 1'b1, q, ak);
            chk({7'h00, ak}, 8'h00, "foreign address");
            bus_master_inst.xfer(8'h01, 1'b1, q, ak);
            bus_master_inst.xfer(8'hE7, 1'b1, q, ak);
            bus_master_inst.stop();
            chk(pin_out, lat, "foreign write");
            open_w(8'h01);
            put({5'h00, strap}, "data");
            bus_master_inst.stop();
            lat = {5'h00, strap};
            chk(pin_out, lat, "strap address");
        end
        $display("address match done");
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(pin_out, 8'hFF, "latch default");
        chk(pin_oe, 8'h00, "all pins input");
        rd(8'h00, 1'b0, 1, ext);
        rd(8'h01, 1'b1, 1, 8'hFF);
        rd(8'h02, 1'b1, 1, 8'h00);
        rd(8'h03, 1'b1, 1, 8'hFF);
        $display("reset done");
        chk({7'h00, irq_n_oe}, 8'h00, "idle interrupt");
        @(posedge ref_clk);
        ext <= 8'h92;
        repeat (10) @(posedge ref_clk);
        chk({7'h00, irq_n_oe}, 8'h01, "pin change interrupt");
        rd(8'h00, 1'b1, 1, 8'h92);
        chk({7'h00, irq_n_oe}, 8'h00, "interrupt cleared by read");
        open_w(8'h03);
        put(8'hFE, "data");
        bus_master_inst.stop();
        repeat (10) @(posedge ref_clk);
        chk({7'h00, irq_n_oe}, 8'h00, "output pin no interrupt");
        rd(8'h00, 1'b1, 1, 8'h93);
        $display("interrupt done");
        report_and_stop();
    end
endmodule
